// ---- rtl/plc_line_coding.sv ----
/*
  Digital line coding of a 10/100 twisted-pair PHY: scrambler, NRZI and
  MLT-3 for the fast mode, Manchester for the slow mode, receive polarity
  correction in the slow mode (and in the fast mode with autoneg set), and a two-entry buffer on the received data.
  Assumes line inputs are sliced levels synchronous to clk_in and that a
  {pos, neg} pair of 1,1 never occurs.
*/
`timescale 1ns/1ps
module plc_line_coding (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic nrst_in,
  // Configuration.
  input wire plc_pkg::plc_cfg_t cfg_in,
  // Transmit data from the MAC side.
  input wire plc_pkg::plc_tx_t tx_in,
  output logic tx_ready_out,
  // Received data to the MAC side.
  output logic rx_valid_out,
  output logic [3:0] rx_data_out,
  input wire logic rx_ready_in,
  output logic rx_overrun_out,
  output logic rx_locked_out,
  output logic rx_pol_inv_out,
  // Twisted pair.
  output logic line_tx_pos_out,
  output logic line_tx_neg_out,
  input wire logic line_rx_pos_in,
  input wire logic line_rx_neg_in
);
  import plc_pkg::*;

  typedef struct packed {
    logic [3:0] div;
    logic [SCR_W-1:0] scr;
    logic nrzi;
    logic [1:0] mlt;
    logic [1:0] tx_lvl;
    logic [3:0] tx_sh;
    logic [2:0] tx_cnt;
    logic tx_half;
    logic [1:0] rx_prev;
    logic [SCR_W-1:0] dsc;
    logic [4:0] sync_cnt;
    plc_ds_state_t ds;
    logic rx_half;
    logic rx_first;
    logic [3:0] rx_sh;
    logic [2:0] rx_cnt;
    logic pol_inv;
    logic [1:0] pol_cnt;
    logic w_valid;
    logic [3:0] w_data;
    logic overrun;
    logic speed_q;
  } plc_st_t;

  plc_st_t st;
  plc_st_t next_st;
  logic tick;
  logic tx_take;
  logic buf_ready;
  logic [1:0] rx_lvl;
  logic [SCR_W-1:0] seed;

  assign tick = st.div == (cfg_in.speed100 ? BIT100_LAST : HALF10_LAST);
  assign tx_take = cfg_in.speed100 ? tick
                 : (tick && !st.tx_half && st.tx_cnt == 3'h0);
  assign tx_ready_out = tx_take;
  assign rx_lvl = st.pol_inv ? {line_rx_neg_in, line_rx_pos_in}
                : {line_rx_pos_in, line_rx_neg_in};
  assign seed = {cfg_in.phy_addr, ~cfg_in.phy_addr, 1'b1};

  always_comb begin
    logic b;
    logic key;
    logic r;
    logic nb;
    logic k_in;
    logic pk;
    logic start;
    b = 1'b0;
    key = 1'b0;
    r = 1'b0;
    nb = 1'b0;
    k_in = 1'b0;
    pk = 1'b0;
    start = 1'b0;
    next_st = st;
    next_st.w_valid = 1'b0;
    next_st.overrun = st.w_valid && !buf_ready;
    next_st.speed_q = cfg_in.speed100;
    next_st.div = tick ? 4'h0 : st.div + 4'h1;
    if (st.speed_q != cfg_in.speed100) begin
      next_st.div = 4'h0;
      next_st.tx_cnt = 3'h0;
      next_st.tx_half = 1'b0;
      next_st.rx_half = 1'b0;
      next_st.rx_cnt = 3'h0;
      next_st.tx_lvl = LVL_ZERO;
      next_st.ds = PLC_DS_HUNT;
      next_st.sync_cnt = 5'h0;
    end else if (tick && cfg_in.speed100) begin
      // Transmit: idle ones fill the gaps between words.
      b = tx_in.valid ? tx_in.data[0] : 1'b1;
      key = st.scr[SCR_TAP_A] ^ st.scr[SCR_TAP_B];
      next_st.scr = {st.scr[SCR_W-2:0], key};
      if (!cfg_in.symbol_if) begin
        b = b ^ key;
      end
      next_st.nrzi = st.nrzi ^ b;
      if (next_st.nrzi != st.nrzi) begin
        next_st.mlt = st.mlt + 2'h1;
      end
      case (next_st.mlt)
        2'h1: next_st.tx_lvl = LVL_PLUS;
        2'h3: next_st.tx_lvl = LVL_MINUS;
        default: next_st.tx_lvl = LVL_ZERO;
      endcase
      // Receive: any change of level is an NRZI one.
      r = (rx_lvl != st.rx_prev);
      next_st.rx_prev = rx_lvl;
      if (cfg_in.symbol_if) begin
        next_st.w_valid = 1'b1;
        next_st.w_data = {3'h0, r};
      end else begin
        pk = st.dsc[SCR_TAP_A] ^ st.dsc[SCR_TAP_B];
        case (st.ds)
          PLC_DS_HUNT: begin
            k_in = ~r;
            next_st.dsc = {st.dsc[SCR_W-2:0], k_in};
            next_st.sync_cnt = (pk == k_in) ? st.sync_cnt + 5'h1 : 5'h0;
            if (st.sync_cnt == SYNC_LEN) begin
              next_st.ds = PLC_DS_LOCK;
            end
          end
          PLC_DS_LOCK: begin
            next_st.dsc = {st.dsc[SCR_W-2:0], pk};
            next_st.w_valid = 1'b1;
            next_st.w_data = {3'h0, r ^ pk};
          end
          default: next_st.ds = PLC_DS_HUNT;
        endcase
      end
    end else if (tick) begin
      // Transmit, slow mode: one half bit per tick.
      if (!st.tx_half) begin
        if (st.tx_cnt == 3'h0) begin
          if (tx_in.valid) begin
            next_st.tx_sh = tx_in.data;
            next_st.tx_cnt = cfg_in.nibble10 ? NIB_BITS : SER_BITS;
            nb = tx_in.data[0];
            next_st.tx_half = 1'b1;
            next_st.tx_lvl = nb ? LVL_PLUS : LVL_MINUS;
          end else begin
            next_st.tx_lvl = LVL_ZERO;
          end
        end else begin
          next_st.tx_half = 1'b1;
          next_st.tx_lvl = st.tx_sh[0] ? LVL_PLUS : LVL_MINUS;
        end
      end else begin
        next_st.tx_half = 1'b0;
        next_st.tx_lvl = st.tx_sh[0] ? LVL_MINUS : LVL_PLUS;
        next_st.tx_sh = {1'b0, st.tx_sh[3:1]};
        next_st.tx_cnt = st.tx_cnt - 3'h1;
      end
      // Receive, slow mode: pair the halves of each bit.
      if (rx_lvl == LVL_ZERO) begin
        next_st.rx_half = 1'b0;
        next_st.rx_cnt = 3'h0;
      end else if (!st.rx_half) begin
        next_st.rx_first = (rx_lvl == LVL_PLUS);
        next_st.rx_half = 1'b1;
      end else if (st.rx_first == (rx_lvl == LVL_PLUS)) begin
        // Two equal halves mean the phase is off: slip by one half.
        next_st.rx_first = (rx_lvl == LVL_PLUS);
      end else begin
        next_st.rx_half = 1'b0;
        nb = st.rx_first;
        if (cfg_in.nibble10) begin
          next_st.rx_sh = {nb, st.rx_sh[3:1]};
          next_st.rx_cnt = st.rx_cnt + 3'h1;
          if (st.rx_cnt == NIB_BITS - 3'h1) begin
            next_st.rx_cnt = 3'h0;
            next_st.w_valid = 1'b1;
            next_st.w_data = {nb, st.rx_sh[3:1]};
          end
        end else begin
          next_st.w_valid = 1'b1;
          next_st.w_data = {3'h0, nb};
        end
      end
    end
    // Polarity: a burst from silence must open positive.
    if (tick && (!cfg_in.speed100 || cfg_in.autoneg)) begin
      start = (st.rx_prev == LVL_ZERO) && (rx_lvl != LVL_ZERO);
      if (start && rx_lvl == LVL_MINUS) begin
        next_st.pol_cnt = st.pol_cnt + 2'h1;
        if (st.pol_cnt == POL_THRESH - 2'h1) begin
          next_st.pol_inv = ~st.pol_inv;
          next_st.pol_cnt = 2'h0;
        end
      end else if (start) begin
        next_st.pol_cnt = 2'h0;
      end
      if (!cfg_in.speed100) begin
        next_st.rx_prev = rx_lvl;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      st <= '0;
      st.scr <= seed;
      st.speed_q <= cfg_in.speed100;
    end else begin
      st <= next_st;
    end
  end

  plc_pair_buf #(
    .W(RXW)
  ) u_rx_buf (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .in_valid_in(st.w_valid),
    .in_data_in(st.w_data),
    .in_ready_out(buf_ready),
    .out_valid_out(rx_valid_out),
    .out_data_out(rx_data_out),
    .out_ready_in(rx_ready_in)
  );

  assign line_tx_pos_out = st.tx_lvl[1];
  assign line_tx_neg_out = st.tx_lvl[0];
  assign rx_overrun_out = st.overrun;
  assign rx_locked_out = (st.ds == PLC_DS_LOCK);
  assign rx_pol_inv_out = st.pol_inv;

endmodule : plc_line_coding

// ---- rtl/plc_pair_buf.sv ----
/*
  Two-entry buffer with valid and ready on both sides.
  Assumes the filling side holds nothing back: a word offered while full is
  refused through in_ready_out.
*/
`timescale 1ns/1ps
module plc_pair_buf #(
  parameter int W = 4
) (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic nrst_in,
  // Filling side.
  input wire logic in_valid_in,
  input wire logic [W-1:0] in_data_in,
  output logic in_ready_out,
  // Draining side.
  output logic out_valid_out,
  output logic [W-1:0] out_data_out,
  input wire logic out_ready_in
);

  typedef struct packed {
    logic [W-1:0] head;
    logic [W-1:0] tail;
    logic [1:0] cnt;
  } plc_buf_st_t;

  plc_buf_st_t st;
  plc_buf_st_t next_st;
  logic push;
  logic pop;

  assign in_ready_out = (st.cnt != 2'h2);
  assign out_valid_out = (st.cnt != 2'h0);
  assign out_data_out = st.head;
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  always_comb begin
    next_st = st;
    if (pop) begin
      next_st.head = st.tail;
    end
    if (push) begin
      if (st.cnt == 2'h0 || (st.cnt == 2'h1 && pop)) begin
        next_st.head = in_data_in;
      end else begin
        next_st.tail = in_data_in;
      end
    end
    next_st.cnt = st.cnt + 2'(push) - 2'(pop);
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule : plc_pair_buf

// ---- rtl/plc_pkg.sv ----
/*
  Shared constants and carrier types of the line-coding block.
  Assumes a single 50 MHz clock; all line rates are enables derived from it.
*/
package plc_pkg;

  // Clock and line timing.
  localparam int CLK_MHZ = 50;
  localparam int BIT100_NS = 10;
  localparam int HALF10_NS = 50;
  localparam int BIT100_RAW = BIT100_NS * CLK_MHZ / 1000;
  localparam int HALF10_RAW = HALF10_NS * CLK_MHZ / 1000;
  localparam int BIT100_CYC = (BIT100_RAW < 1) ? 1 : BIT100_RAW;
  localparam int HALF10_CYC = (HALF10_RAW < 1) ? 1 : HALF10_RAW;
  localparam logic [3:0] BIT100_LAST = 4'(BIT100_CYC - 1);
  localparam logic [3:0] HALF10_LAST = 4'(HALF10_CYC - 1);

  // Scrambler and descrambler.
  localparam int SCR_W = 11;
  localparam int SCR_TAP_A = 10;
  localparam int SCR_TAP_B = 8;
  localparam logic [4:0] SYNC_LEN = 5'h1e;

  // Polarity correction.
  localparam logic [1:0] POL_THRESH = 2'h2;

  // Line levels as {pos, neg}.
  localparam logic [1:0] LVL_ZERO = 2'h0;
  localparam logic [1:0] LVL_PLUS = 2'h2;
  localparam logic [1:0] LVL_MINUS = 2'h1;

  // Nibble and serial widths.
  localparam logic [2:0] NIB_BITS = 3'h4;
  localparam logic [2:0] SER_BITS = 3'h1;

  // Received-data buffer.
  localparam int RXW = 4;

  typedef enum logic [0:0] {
    PLC_DS_HUNT = 1'b0,
    PLC_DS_LOCK = 1'b1
  } plc_ds_state_t;

  typedef struct packed {
    logic speed100;
    logic symbol_if;
    logic nibble10;
    logic autoneg;
    logic [4:0] phy_addr;
  } plc_cfg_t;

  typedef struct packed {
    logic valid;
    logic [3:0] data;
  } plc_tx_t;

endpackage : plc_pkg

// ---- test/plc_line_coding_sva.sv ----
/*
  Property checker for the line-coding block, bound to its ports.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module plc_line_coding_sva (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic nrst_in,
  // Watched ports.
  input wire plc_pkg::plc_cfg_t cfg_in,
  input wire plc_pkg::plc_tx_t tx_in,
  input wire logic tx_ready_out,
  input wire logic rx_valid_out,
  input wire logic [3:0] rx_data_out,
  input wire logic rx_ready_in,
  input wire logic rx_overrun_out,
  input wire logic rx_locked_out,
  input wire logic rx_pol_inv_out,
  input wire logic line_tx_pos_out,
  input wire logic line_tx_neg_out,
  input wire logic line_rx_pos_in,
  input wire logic line_rx_neg_in
);
  import plc_pkg::*;
  logic [1:0] lvl;
  assign lvl = {line_tx_pos_out, line_tx_neg_out};
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  sequence take10;
    !cfg_in.speed100 && tx_in.valid && tx_ready_out;
  endsequence
  sequence stall;
    rx_valid_out && !rx_ready_in;
  endsequence
  never_both_a: assert property (lvl != 2'h3)
    else $error("both line outputs high");
  mlt_step_a: assert property (
    cfg_in.speed100 && lvl != LVL_ZERO && $past(lvl) != LVL_ZERO
    |-> lvl == $past(lvl)) else $error("level jumped across zero");
  half_hold_a: assert property (
    !cfg_in.speed100 && $changed(lvl) && lvl != LVL_ZERO |=> $stable(lvl))
    else $error("half bit shorter than two cycles");
  slow_take_a: assert property (
    take10 |=> (lvl != LVL_ZERO && !tx_ready_out) [*3])
    else $error("slow word not sent at once");
  fast_ready_a: assert property (
    cfg_in.speed100 && $past(nrst_in) |-> tx_ready_out)
    else $error("fast mode did not take a bit");
  ovr_full_a: assert property (
    rx_overrun_out |-> $past(rx_valid_out && !rx_ready_in))
    else $error("overrun without a stall");
  hold_data_a: assert property (
    stall |=> rx_valid_out && $stable(rx_data_out))
    else $error("buffered word lost in stall");
  lock_keep_a: assert property (
    rx_locked_out && !$changed(cfg_in.speed100) |=> rx_locked_out)
    else $error("lock dropped");
  pol_mode_a: assert property (
    $changed(rx_pol_inv_out) |-> $past(!cfg_in.speed100 || cfg_in.autoneg))
    else $error("polarity changed in wrong mode");
endmodule : plc_line_coding_sva
bind plc_line_coding plc_line_coding_sva plc_line_coding_sva_inst (.*);

// ---- test/plc_line_coding_tb.sv ----
/*
  Self-checking bench: loopback through a medium model, with a
  reference model of scrambler, MLT-3 and Manchester.
  Assumes 50 MHz clock and synchronous active-low reset.
*/
`timescale 1ns/1ps
module plc_line_coding_tb;
  import plc_pkg::*;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  plc_cfg_t cfg = '0;
  plc_tx_t tx = '0;
  logic rx_ready = 1'b1;
  logic swap = 1'b0;
  logic rx_chk = 1'b0;
  logic started = 1'b0;
  logic ovr_seen = 1'b0;
  logic tx_ready, rx_valid, ovr, locked, pol, tp, tn, rp, rn, rdy_n, b, k;
  logic [3:0] rx_data, d;
  logic [SCR_W-1:0] s;
  logic [1:0] ph;
  logic [1:0] e_mlt;
  logic [3:0] rx_got;
  logic [3:0] rq[$];
  int n_fail = 0;
  int n_checks = 0;
  always #10 clk_in = ~clk_in;
  plc_line_coding plc_line_coding_inst (.clk_in(clk_in), .nrst_in(nrst_in),
    .cfg_in(cfg), .tx_in(tx), .tx_ready_out(tx_ready),
    .rx_valid_out(rx_valid), .rx_data_out(rx_data), .rx_ready_in(rx_ready),
    .rx_overrun_out(ovr), .rx_locked_out(locked), .rx_pol_inv_out(pol),
    .line_tx_pos_out(tp), .line_tx_neg_out(tn), .line_rx_pos_in(rp),
    .line_rx_neg_in(rn));
  plc_medium plc_medium_inst (.clk_in(clk_in), .swap_in(swap),
    .tx_pos_in(tp), .tx_neg_in(tn), .rx_pos_out(rp), .rx_neg_out(rn));
  task automatic check(input string what, input logic [3:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic final_report;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report
  task automatic rst(input plc_cfg_t c);
    @(posedge clk_in);
    nrst_in <= 1'b0;
    cfg <= c;
    tx <= '0;
    rx_chk <= 1'b0;
    repeat (3) @(posedge clk_in);
    nrst_in <= 1'b1;
  endtask : rst
  task automatic send10(input logic [3:0] v, input int nb);
    int w;
    logic [1:0] e;
    @(posedge clk_in);
    tx <= '{1'b1, v};
    w = 0;
    do begin @(negedge clk_in); w++; end while (tx_ready !== 1'b1 && w < 99);
    check("take", 4'(tx_ready), 4'h1);
    @(posedge clk_in);
    tx <= '0;
    for (int i = 0; i < nb * 4; i++) begin
      @(negedge clk_in);
      e = (v[i/4] ^ (i % 4 > 1)) ? LVL_PLUS : LVL_MINUS;
      check("man", 4'({tp, tn}), 4'(e));
    end
    @(negedge clk_in);
    check("idle", 4'({tp, tn}), 4'(LVL_ZERO));
  endtask : send10
  always @(negedge clk_in) begin
    rdy_n = tx_ready;
    e_mlt = ph[0] ? (ph[1] ? LVL_MINUS : LVL_PLUS) : LVL_ZERO;
    if (nrst_in && cfg.speed100) begin
      check("mlt", 4'({tp, tn}), 4'(e_mlt));
    end
  end
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      s = {cfg.phy_addr, ~cfg.phy_addr, 1'b1};
      ph = 2'h0;
    end else if (cfg.speed100 && rdy_n) begin
      b = tx.valid ? tx.data[0] : 1'b1;
      k = s[SCR_TAP_A] ^ s[SCR_TAP_B];
      s = {s[SCR_W-2:0], k};
      if (b ^ (k & !cfg.symbol_if)) ph = ph + 2'h1;
    end
    if (ovr === 1'b1) ovr_seen = 1'b1;
    if (rx_chk && rx_valid && rx_ready) begin
      if (cfg.speed100 && !started) started = !rx_data[0];
      if (started && rq.size() > 0) begin
        rx_got = rx_data & (cfg.speed100 ? 4'h1 : 4'hf);
        check("rx", rx_got, rq.pop_front());
      end
    end
  end
  initial begin
    repeat (20000) @(posedge clk_in);
    n_fail++;
    final_report();
  end
  initial begin
    void'($urandom(32'h63194fbf));
    for (int m = 0; m < 2; m++) begin
      rst('{1'b1, m[0], 1'b0, m[0], 5'($urandom)});
      repeat (80) @(posedge clk_in);
      check("lock", 4'(locked), 4'(!m[0]));
      rx_chk <= 1'b1;
      started = 1'b0;
      repeat (10) @(posedge clk_in);
      for (int i = 0; i < 40; i++) begin
        d = 4'($urandom) & {3'h7, i != 0};
        tx <= '{1'b1, d};
        rq.push_back({3'h0, d[0]});
        @(posedge clk_in);
      end
      tx <= '0;
      repeat (30) @(posedge clk_in);
      check("rxq", 4'(rq.size()), 4'h0);
      check("pol", 4'(pol), 4'h0);
      rq.delete();
    end
    rst('{1'b0, 1'b0, 1'b1, 1'b0, 5'h0});
    swap <= 1'b1;
    started = 1'b1;
    for (int i = 0; i < 6; i++) begin
      d = 4'($urandom) | 4'h1;
      rx_ready <= (i < 2 || i > 4);
      if (i >= 2 && i != 4) rq.push_back(d);
      if (i == 2) rx_chk <= 1'b1;
      send10(d, 4);
      repeat (12) @(posedge clk_in);
    end
    check("pol", 4'(pol), 4'h1);
    check("rxq", 4'(rq.size()), 4'h0);
    check("ovr", 4'(ovr_seen), 4'h1);
    rst('{1'b0, 1'b0, 1'b0, 1'b0, 5'h0});
    swap <= 1'b0;
    rx_chk <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      d = 4'($urandom) | 4'(i % 2 == 0);
      rq.push_back({3'h0, d[0]});
      send10(d, 1);
      repeat (4) @(posedge clk_in);
    end
    check("rxq", 4'(rq.size()), 4'h0);
    check("pol", 4'(pol), 4'h0);
    final_report();
  end
endmodule : plc_line_coding_tb

// ---- test/plc_medium.sv ----
/*
  Twisted-pair medium: one clock of flight and optional crossed wires.
  Assumes the transmit pair never shows 1,1.
*/
`timescale 1ns/1ps
module plc_medium (
  // Clock and wiring fault.
  input wire logic clk_in,
  input wire logic swap_in,
  // Near end.
  input wire logic tx_pos_in,
  input wire logic tx_neg_in,
  // Far end.
  output logic rx_pos_out = 1'b0,
  output logic rx_neg_out = 1'b0
);
  always @(posedge clk_in) begin
    rx_pos_out <= swap_in ? tx_neg_in : tx_pos_in;
    rx_neg_out <= swap_in ? tx_pos_in : tx_neg_in;
  end
endmodule : plc_medium
